//--- logic/fltl_trigger_bank.sv
// Behaviour
// [R1] overvoltage on inputs 1 to 3 starts a log when 49h bits 4 to 6 are set.
// [R2] bit 7 of 49h enables the overvoltage log for input 4.
// [R3] overvoltage on inputs 5 to 8 is gated by 4Ah bits 0 to 3.
// [R4] on the twelve-channel variant, inputs 9 to 12 use 4Ah bits 4 to 7.
// [R5] early-warning crossings on inputs 1 to 8 are gated by 4Bh bits 0 to 7.
// [R6] twelve-channel early warnings 9 to 12 use 4Ch bits 0 to 3; 7 to 4 idle.
// [R7] 47h[1:0] picks the log content: both, flags, conversions, or nothing.
// [R8] a log locks the store until software writes one to the unlock bit.
// [R9] 48h bits 0 to 7 gate undervoltage logs for inputs 1 to 8.
// [R10] each logged conversion keeps only its eight most significant bits.
`include "fltl_regs.svh"

module fltl_trigger_bank #(
  parameter bit TWELVE_CH = 1'b1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire fltl_pkg::fltl_cfg_req_t cfg_req,
  output fltl_pkg::fltl_cfg_rsp_t cfg_rsp,
  input wire logic [11:0] monitored_input_ov,
  input wire logic [11:0] monitored_input_uv,
  input wire logic [11:0] monitored_input_ew,
  input wire fltl_pkg::fltl_conv_arr_t monitored_input_conv,
  output logic fault_log_trigger,
  output logic log_locked,
  output logic log_busy
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [1:0] log_ctrl_reg;
  logic [7:0] uv_log_enable_low_reg, uv_ov_log_enable_mixed_reg;
  logic [7:0] ov_log_enable_upper_reg, early_warn_log_enable_low_reg;
  logic [3:0] early_warn_log_enable_high_reg;
  fltl_pkg::fltl_state_t state_reg;
  logic [3:0] idx_reg, last_reg;
  logic [11:0] snap_flags_reg;
  fltl_pkg::fltl_conv_arr_t snap_conv_reg;
  logic [7:0] addr_p1_reg, regdata_p1_reg, mem_rdata, mem_wdata;
  logic [11:0] ov_en, uv_en, ew_en, chan_mask, hit;
  logic lock_reg, rd_p1_reg, armed, trig_now, unlock_wr, mem_we;
  function automatic logic cfg_hit(input fltl_pkg::fltl_cfg_req_t r,
                                   input logic [7:0] a);
    cfg_hit = r.wr && (r.addr == a);
  endfunction
  // one log byte from the captured flags and conversions
  function automatic logic [7:0] log_byte(
    input logic [3:0] idx,
    input logic [11:0] flags,
    input fltl_pkg::fltl_conv_arr_t conv);
    log_byte = 8'h00;
    if (idx == `FLTL_LOG_FLAGS_LO) begin
      log_byte = flags[7:0];
    end else if (idx == `FLTL_LOG_FLAGS_HI) begin
      log_byte = {4'h0, flags[11:8]};
    end else begin
      for (int i = 0; i < 12; i++) begin
        if (idx == 4'(i + 3)) begin
          log_byte = conv[i][9:2];
        end
      end
    end
  endfunction
  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // [R7] content select
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      log_ctrl_reg <= `FLTL_RST_MODE;
    end else if (cfg_hit(cfg_req, `FLTL_ADDR_LOG_CTRL)) begin
      log_ctrl_reg <= cfg_req.wdata[1:0];
    end
  end
  // enable bytes; 4Ch keeps only its low nibble
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      uv_log_enable_low_reg <= `FLTL_RST_ENABLE;
      uv_ov_log_enable_mixed_reg <= `FLTL_RST_ENABLE;
      ov_log_enable_upper_reg <= `FLTL_RST_ENABLE;
      early_warn_log_enable_low_reg <= `FLTL_RST_ENABLE;
      early_warn_log_enable_high_reg <= 4'h0;
    end else begin
      if (cfg_hit(cfg_req, `FLTL_ADDR_UV_EN_LOW)) begin
        uv_log_enable_low_reg <= cfg_req.wdata;
      end
      if (cfg_hit(cfg_req, `FLTL_ADDR_UV_OV_EN_MIXED)) begin
        uv_ov_log_enable_mixed_reg <= cfg_req.wdata;
      end
      if (cfg_hit(cfg_req, `FLTL_ADDR_OV_EN_UPPER)) begin
        ov_log_enable_upper_reg <= cfg_req.wdata;
      end
      if (cfg_hit(cfg_req, `FLTL_ADDR_EW_EN_LOW)) begin
        early_warn_log_enable_low_reg <= cfg_req.wdata;
      end
      // [R6] upper nibble idle
      if (cfg_hit(cfg_req, `FLTL_ADDR_EW_EN_HIGH)) begin
        early_warn_log_enable_high_reg <= cfg_req.wdata[3:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // trigger decode
  // ----------------------------------------------------------------
  // [R1] inputs 1 to 3 at 49h[6:4]
  // [R2] input 4 at 49h[7]
  // [R3] inputs 5 to 8 at 4Ah[3:0]
  // [R4] inputs 9 to 12 at 4Ah[7:4]
  assign ov_en = {ov_log_enable_upper_reg, uv_ov_log_enable_mixed_reg[7:4]};
  // [R9] undervoltage gating
  assign uv_en = {uv_ov_log_enable_mixed_reg[3:0], uv_log_enable_low_reg};
  // [R5] early-warning gating
  assign ew_en = {early_warn_log_enable_high_reg,
                  early_warn_log_enable_low_reg};
  // [R4] eight-channel variant ignores inputs 9 to 12
  assign chan_mask = TWELVE_CH ? 12'hFFF : 12'h0FF;
  assign hit = ((monitored_input_ov & ov_en) | (monitored_input_uv & uv_en)
               | (monitored_input_ew & ew_en)) & chan_mask;
  // [R7] content 11 turns the logger off
  assign armed = (state_reg == fltl_pkg::FLTL_IDLE) && !lock_reg
                 && (log_ctrl_reg != `FLTL_MODE_OFF);
  assign trig_now = armed && (|hit);
  assign unlock_wr = cfg_hit(cfg_req, `FLTL_ADDR_LOG_UNLOCK)
                     && cfg_req.wdata[`FLTL_UNLOCK_BIT];
  // ----------------------------------------------------------------
  // lock and store sequence
  // ----------------------------------------------------------------
  // [R8] lock on trigger, a trigger wins over unlock
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lock_reg <= 1'b0;
    end else if (trig_now) begin
      lock_reg <= 1'b1;
    end else if (unlock_wr) begin
      lock_reg <= 1'b0;
    end
  end
  // snapshot at the trigger so a moving input cannot tear the log
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      snap_flags_reg <= 12'h000;
      snap_conv_reg <= '0;
    end else if (trig_now) begin
      snap_flags_reg <= (monitored_input_ov | monitored_input_uv
                         | monitored_input_ew) & chan_mask;
      snap_conv_reg <= monitored_input_conv;
    end
  end
  // [R7] byte range from the content select
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= fltl_pkg::FLTL_IDLE;
      idx_reg <= 4'h0;
      last_reg <= 4'h0;
    end else begin
      case (state_reg)
        fltl_pkg::FLTL_IDLE: begin
          if (trig_now) begin
            state_reg <= fltl_pkg::FLTL_STORE;
            idx_reg <= (log_ctrl_reg == `FLTL_MODE_CONV) ?
                       `FLTL_LOG_CONV_FIRST : `FLTL_LOG_FLAGS_LO;
            last_reg <= (log_ctrl_reg == `FLTL_MODE_FLAGS) ?
                        `FLTL_LOG_FLAGS_HI : `FLTL_LOG_CONV_LAST;
          end
        end
        fltl_pkg::FLTL_STORE: begin
          if (idx_reg == last_reg) begin
            state_reg <= fltl_pkg::FLTL_IDLE;
          end
          idx_reg <= idx_reg + 4'h1;
        end
        default: begin
          state_reg <= fltl_pkg::FLTL_IDLE;
        end
      endcase
    end
  end
  // [R10] conversions stored as top eight bits
  assign mem_we = (state_reg == fltl_pkg::FLTL_STORE);
  assign mem_wdata = log_byte(idx_reg, snap_flags_reg, snap_conv_reg);
  fltl_log_mem u_log_mem (
    .mclk(mclk),
    .we(mem_we),
    .waddr(idx_reg),
    .wdata(mem_wdata),
    .raddr(cfg_req.addr[3:0]),
    .rdata(mem_rdata)
  );
  // ----------------------------------------------------------------
  // read path and status outputs
  // ----------------------------------------------------------------
  // first stage latches the register view, memory reads in parallel
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_p1_reg <= 1'b0;
      addr_p1_reg <= 8'h00;
      regdata_p1_reg <= 8'h00;
    end else begin
      rd_p1_reg <= cfg_req.rd;
      addr_p1_reg <= cfg_req.addr;
      case (cfg_req.addr)
        `FLTL_ADDR_LOG_CTRL: regdata_p1_reg <= {6'h00, log_ctrl_reg};
        `FLTL_ADDR_UV_EN_LOW: regdata_p1_reg <= uv_log_enable_low_reg;
        `FLTL_ADDR_UV_OV_EN_MIXED:
          regdata_p1_reg <= uv_ov_log_enable_mixed_reg;
        `FLTL_ADDR_OV_EN_UPPER: regdata_p1_reg <= ov_log_enable_upper_reg;
        `FLTL_ADDR_EW_EN_LOW:
          regdata_p1_reg <= early_warn_log_enable_low_reg;
        `FLTL_ADDR_EW_EN_HIGH:
          regdata_p1_reg <= {4'h0, early_warn_log_enable_high_reg};
        `FLTL_ADDR_LOG_UNLOCK: regdata_p1_reg <= {7'h00, lock_reg};
        default: regdata_p1_reg <= 8'h00;
      endcase
    end
  end
  // second stage answers; unmapped addresses above 0Eh read zero
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.valid <= rd_p1_reg;
      cfg_rsp.rdata <= (addr_p1_reg <= `FLTL_ADDR_LOG_LAST) ?
                       mem_rdata : regdata_p1_reg;
    end
  end
  // status flops
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fault_log_trigger <= 1'b0;
      log_locked <= 1'b0;
      log_busy <= 1'b0;
    end else begin
      fault_log_trigger <= trig_now;
      log_locked <= lock_reg || trig_now;
      log_busy <= trig_now || (mem_we && (idx_reg != last_reg));
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_OV_LOW_TRIG: // [R1]
    assert property (armed && monitored_input_ov[0]
                     && uv_ov_log_enable_mixed_reg[4] |=> fault_log_trigger)
    else $error("overvoltage on input 1 did not trigger");
  AST_OV4_TRIG: // [R2]
    assert property (armed && monitored_input_ov[3]
                     && uv_ov_log_enable_mixed_reg[7] |=> fault_log_trigger)
    else $error("overvoltage on input 4 did not trigger");
  AST_OV_MID_TRIG: // [R3]
    assert property (armed && monitored_input_ov[4]
                     && ov_log_enable_upper_reg[0] |=> fault_log_trigger)
    else $error("overvoltage on input 5 did not trigger");
  AST_OV_HIGH_TRIG: // [R4]
    assert property (armed && monitored_input_ov[11]
                     && ov_log_enable_upper_reg[7] && hit[10:0] == 11'h000
                     |=> fault_log_trigger == TWELVE_CH)
    else $error("input 12 overvoltage gating wrong");
  AST_EW_LOW_TRIG: // [R5]
    assert property (armed && monitored_input_ew[7]
                     && early_warn_log_enable_low_reg[7]
                     |=> fault_log_trigger)
    else $error("early warning on input 8 did not trigger");
  AST_EW_HIGH_READ: // [R6]
    assert property (rd_p1_reg && addr_p1_reg == `FLTL_ADDR_EW_EN_HIGH
                     |=> cfg_rsp.valid && cfg_rsp.rdata[7:4] == 4'h0)
    else $error("idle nibble of early warning high read nonzero");
  AST_LOG_OFF: // [R7]
    assert property (log_ctrl_reg == `FLTL_MODE_OFF |=> !fault_log_trigger)
    else $error("logger off but a log started");
  AST_FLAGS_ONLY_LEN: // [R7]
    assert property (fault_log_trigger && last_reg == `FLTL_LOG_FLAGS_HI
                     |-> mem_we ##1 mem_we ##1 !mem_we)
    else $error("flags-only log wrong length");
  AST_LOCK_HOLD: // [R8]
    assert property (fault_log_trigger |-> log_locked && lock_reg)
    else $error("trigger did not lock");
  AST_NO_TRIG_LOCKED: // [R8]
    assert property (lock_reg |=> !fault_log_trigger)
    else $error("log started while locked");
  AST_UV_TRIG: // [R9]
    assert property (armed && monitored_input_uv[0]
                     && uv_log_enable_low_reg[0] |=> fault_log_trigger)
    else $error("undervoltage on input 1 did not trigger");
  AST_CONV_TRUNC: // [R10]
    assert property (mem_we && idx_reg == `FLTL_LOG_CONV_FIRST
                     |-> mem_wdata == snap_conv_reg[0][9:2])
    else $error("conversion not truncated to top bits");
  COV_FULL_LOG: cover property (fault_log_trigger
                                && log_ctrl_reg == 2'h0);
  COV_UNLOCK: cover property (lock_reg && unlock_wr);
  COV_STORE_DONE: cover property (mem_we && idx_reg == last_reg);
endmodule

//--- logic/fltl_regs.svh
`ifndef FLTL_REGS_SVH
`define FLTL_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FLTL_ADDR_LOG_CTRL 8'h47
`define FLTL_ADDR_UV_EN_LOW 8'h48
`define FLTL_ADDR_UV_OV_EN_MIXED 8'h49
`define FLTL_ADDR_OV_EN_UPPER 8'h4A
`define FLTL_ADDR_EW_EN_LOW 8'h4B
`define FLTL_ADDR_EW_EN_HIGH 8'h4C
`define FLTL_ADDR_LOG_UNLOCK 8'h5D
`define FLTL_ADDR_LOG_LAST 8'h0E

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define FLTL_UNLOCK_BIT 1
`define FLTL_MODE_OFF 2'h3
`define FLTL_MODE_FLAGS 2'h1
`define FLTL_MODE_CONV 2'h2
`define FLTL_LOG_FLAGS_LO 4'h1
`define FLTL_LOG_FLAGS_HI 4'h2
`define FLTL_LOG_CONV_FIRST 4'h3
`define FLTL_LOG_CONV_LAST 4'hE

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FLTL_RST_ENABLE 8'h00
`define FLTL_RST_MODE 2'h0

`endif

//--- logic/fltl_pkg.sv
package fltl_pkg;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef logic [11:0][9:0] fltl_conv_arr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fltl_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } fltl_cfg_rsp_t;

  typedef enum logic [0:0] {
    FLTL_IDLE = 1'b0,
    FLTL_STORE = 1'b1
  } fltl_state_t;

endpackage

//--- logic/fltl_log_mem.sv
// small log store, one write port and one registered read port
module fltl_log_mem (
  input wire logic mclk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:15];

  // write port, no reset: contents survive like the nonvolatile log
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end

endmodule

//--- tb/tb_fault_log_trigger_enables.sv
`include "fltl_regs.svh"

module tb_fault_log_trigger_enables;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk;
  logic reset_n;
  fltl_pkg::fltl_cfg_req_t cfg_req;
  fltl_pkg::fltl_cfg_rsp_t cfg_rsp;
  logic [11:0] ov_hit;
  logic [11:0] uv_hit;
  logic [11:0] ew_hit;
  fltl_pkg::fltl_conv_arr_t conv;
  logic fault_log_trigger;
  logic log_locked;
  logic log_busy;
  logic fault_log_trigger_8;
  int fails;
  int n_checks;

  fltl_trigger_bank dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp),
    .monitored_input_ov(ov_hit),
    .monitored_input_uv(uv_hit),
    .monitored_input_ew(ew_hit),
    .monitored_input_conv(conv),
    .fault_log_trigger(fault_log_trigger),
    .log_locked(log_locked),
    .log_busy(log_busy)
  );

  // eight-channel variant on the same stimulus: inputs 9 to 12 must stay
  // silent there, which the twelve-channel instance cannot show
  fltl_trigger_bank #(
    .TWELVE_CH(1'b0)
  ) dut8 (
    .mclk(mclk),
    .reset_n(reset_n),
    .cfg_req(cfg_req),
    .cfg_rsp(),
    .monitored_input_ov(ov_hit),
    .monitored_input_uv(uv_hit),
    .monitored_input_ew(ew_hit),
    .monitored_input_conv(conv),
    .fault_log_trigger(fault_log_trigger_8),
    .log_locked(),
    .log_busy()
  );

  // free-running clock, 4 ns period
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write pulse, launched on the falling edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    cfg_req.wr = 1'b1;
    cfg_req.addr = a;
    cfg_req.wdata = d;
    @(negedge mclk);
    cfg_req.wr = 1'b0;
  endtask

  // read and compare; the answer is waited for under a small bound
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    int k;
    @(negedge mclk);
    cfg_req.rd = 1'b1;
    cfg_req.addr = a;
    @(negedge mclk);
    cfg_req.rd = 1'b0;
    k = 0;
    while (cfg_rsp.valid !== 1'b1 && k < 4) begin
      @(negedge mclk);
      k++;
    end
    check1(cfg_rsp.valid, 1'b1);
    check8(cfg_rsp.rdata, exp);
  endtask

  // trigger is a single pulse, so every falling edge is looked at
  task automatic watch_trig(input logic exp, input logic exp8);
    logic seen;
    logic seen8;
    seen = 1'b0;
    seen8 = 1'b0;
    repeat (3) begin
      @(negedge mclk);
      if (fault_log_trigger === 1'b1) seen = 1'b1;
      if (fault_log_trigger_8 === 1'b1) seen8 = 1'b1;
    end
    check1(seen, exp);
    check1(seen8, exp8);
  endtask

  task automatic wait_idle();
    int k;
    ov_hit = 12'h000;
    uv_hit = 12'h000;
    ew_hit = 12'h000;
    k = 0;
    while (log_busy !== 1'b0 && k < 40) begin
      @(negedge mclk);
      k++;
    end
    check1(log_busy, 1'b0);
  endtask

  // the store stays locked until software writes the unlock bit
  task automatic release_log();
    wait_idle();
    reg_wr(`FLTL_ADDR_LOG_UNLOCK, 8'h02);
    @(negedge mclk);
    check1(log_locked, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values, read-back masks and unmapped places
  task automatic t_regs();
    for (int a = 8'h47; a <= 8'h4C; a++) begin
      rd_chk(a[7:0], 8'h00);
    end
    rd_chk(`FLTL_ADDR_LOG_UNLOCK, 8'h00);
    for (int a = 8'h48; a <= 8'h4C; a++) begin
      reg_wr(a[7:0], 8'hA5);
      rd_chk(a[7:0], (a == 8'h4C) ? 8'h05 : 8'hA5);
      reg_wr(a[7:0], 8'h00);
    end
    reg_wr(`FLTL_ADDR_LOG_CTRL, 8'hFF);
    rd_chk(`FLTL_ADDR_LOG_CTRL, 8'h03);
    reg_wr(8'h60, 8'hFF);
    rd_chk(8'h60, 8'h00);
  endtask

  // one enable bit, one source: cross-wired bits must not fire
  task automatic t_channel(input int kind, input int ch);
    logic [7:0] a;
    int b;
    logic [11:0] m;
    m = 12'h001 << ch;
    if (kind == 0) begin
      a = (ch < 4) ? `FLTL_ADDR_UV_OV_EN_MIXED : `FLTL_ADDR_OV_EN_UPPER;
      b = (ch < 4) ? ch + 4 : ch - 4;
    end else if (kind == 1) begin
      a = (ch < 8) ? `FLTL_ADDR_EW_EN_LOW : `FLTL_ADDR_EW_EN_HIGH;
      b = (ch < 8) ? ch : ch - 8;
    end else begin
      a = (ch < 8) ? `FLTL_ADDR_UV_EN_LOW : `FLTL_ADDR_UV_OV_EN_MIXED;
      b = (ch < 8) ? ch : ch - 8;
    end
    reg_wr(a, 8'h01 << b);
    ov_hit = (kind == 0) ? ~m : m;
    ew_hit = (kind == 1) ? ~m : m;
    uv_hit = (kind == 2) ? ~m : m;
    watch_trig(1'b0, 1'b0);
    ov_hit = m;
    ew_hit = m;
    uv_hit = m;
    watch_trig(1'b1, (ch < 8));
    check1(log_locked, 1'b1);
    release_log();
    reg_wr(a, 8'h00);
  endtask

  // log contents per mode, truncation, lock against a second log
  task automatic t_content();
    for (int i = 0; i < 12; i++) begin
      conv[i] = {8'hA0 + 8'(i), 2'h3};
    end
    reg_wr(`FLTL_ADDR_LOG_CTRL, 8'h00);
    reg_wr(`FLTL_ADDR_UV_OV_EN_MIXED, 8'h20);
    ov_hit = 12'h002;
    uv_hit = 12'h800;
    watch_trig(1'b1, 1'b1);
    wait_idle();
    rd_chk(8'h01, 8'h02);
    rd_chk(8'h02, 8'h08);
    for (int i = 0; i < 12; i++) begin
      rd_chk(8'h03 + 8'(i), 8'hA0 + 8'(i));
    end
    rd_chk(`FLTL_ADDR_LOG_UNLOCK, 8'h01);
    ov_hit = 12'h002;
    watch_trig(1'b0, 1'b0);
    release_log();
    // flags only: conversion bytes keep the old log
    reg_wr(`FLTL_ADDR_LOG_CTRL, 8'h01);
    conv[0] = {8'h11, 2'h0};
    ov_hit = 12'h002;
    ew_hit = 12'h001;
    watch_trig(1'b1, 1'b1);
    wait_idle();
    rd_chk(8'h01, 8'h03);
    rd_chk(8'h03, 8'hA0);
    release_log();
    // conversions only: flag bytes keep the old log
    reg_wr(`FLTL_ADDR_LOG_CTRL, 8'h02);
    ov_hit = 12'h002;
    watch_trig(1'b1, 1'b1);
    wait_idle();
    rd_chk(8'h01, 8'h03);
    rd_chk(8'h03, 8'h11);
    release_log();
    // logger switched off
    reg_wr(`FLTL_ADDR_LOG_CTRL, 8'h03);
    ov_hit = 12'h002;
    watch_trig(1'b0, 1'b0);
    check1(log_locked, 1'b0);
    wait_idle();
  endtask

  // ----------------------------------------------------------------
  // verdict, sequence and watchdog
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence: reset for 20 cycles, then each scenario in turn
  initial begin
    fails = 0;
    n_checks = 0;
    reset_n = 1'b0;
    cfg_req = '0;
    ov_hit = 12'h000;
    uv_hit = 12'h000;
    ew_hit = 12'h000;
    conv = '0;
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    check1(fault_log_trigger, 1'b0);
    check1(log_locked, 1'b0);
    check1(log_busy, 1'b0);
    t_regs();
    reg_wr(`FLTL_ADDR_LOG_CTRL, 8'h01);
    for (int ch = 0; ch < 12; ch++) begin
      t_channel(0, ch);
      t_channel(1, ch);
      t_channel(2, ch);
    end
    t_content();
    final_report();
  end

  // generous bound: the sequence needs under a thousand cycles, the bound is 20000
  initial begin
    #80000;
    fails++;
    final_report();
  end

endmodule
